//--- inc/etcp_defs.svh
// Functional notes
// - Compare output mode: initial level bit sets pin level before any compare match.
// - PWM and single pulse modes: initial level bit picks active high or low.
// - Initial level bit meaning follows mode; no pin effect in timer/counter mode.
// - Invert bit: 0 passes output, 1 inverts it; ignored in timer/counter mode.
// - Alignment field: 00 edge, 01 centre up, 10 centre down, 11 centre both.
// - Ten-bit counter read only: low byte bits 7..0, high byte bits 9..8.
// - Bits 7..2 of counter and compare high bytes read as zero.
// - Compare value A: ten-bit read/write in low and high bytes, reset zero.
// - Compare value B: ten-bit read/write in low and high bytes, reset zero.
// - Five modes chosen by separate two-bit mode fields for channels A and B; code decodes only the B field, A field is stored but unused.
// - Both mode fields zero select compare match output mode.
// - Both mode fields all ones select timer/counter; pin not driven.
// - Mode 10 with pin-action 10 selects PWM output mode.
// - Run bit rising edge returns pin to the initial level in compare output mode.
`ifndef ETCP_DEFS_SVH
`define ETCP_DEFS_SVH

`define ETCP_OFS_CNT_LO   12'h000
`define ETCP_OFS_CNT_HI   12'h004
`define ETCP_OFS_CMPA_LO  12'h008
`define ETCP_OFS_CMPA_HI  12'h00C
`define ETCP_OFS_CMPB_LO  12'h010
`define ETCP_OFS_CMPB_HI  12'h014
`define ETCP_OFS_CTRL     12'h018
`define ETCP_OFS_STAT     12'h01C

`define ETCP_CTRL_RUN     0
`define ETCP_CTRL_ALIGN   1
`define ETCP_CTRL_INVERT  3
`define ETCP_CTRL_INIT    4
`define ETCP_CTRL_BACT    5
`define ETCP_CTRL_BMODE   7
`define ETCP_CTRL_AMODE   9

`define ETCP_CTRL_RST     32'h0000_0000
`define ETCP_CMP_RST      10'h000

`endif

//--- inc/etcp_pkg.sv
package etcp_pkg;
  typedef enum logic [1:0] {
    ETCP_MODE_COMPARE = 2'b00,
    ETCP_MODE_CAPTURE = 2'b01,
    ETCP_MODE_PWM     = 2'b10,
    ETCP_MODE_TIMER   = 2'b11
  } etcp_mode_t;

  typedef enum logic [1:0] {
    ETCP_ACT_NONE   = 2'b00,
    ETCP_ACT_LOW    = 2'b01,
    ETCP_ACT_HIGH   = 2'b10,
    ETCP_ACT_TOGGLE = 2'b11
  } etcp_act_t;

  typedef enum logic [1:0] {
    ETCP_PWMA_FORCE_OFF = 2'b00,
    ETCP_PWMA_FORCE_ON  = 2'b01,
    ETCP_PWMA_PWM       = 2'b10,
    ETCP_PWMA_SINGLE    = 2'b11
  } etcp_pwm_act_t;

  typedef enum logic [1:0] {
    ETCP_ALIGN_EDGE = 2'b00,
    ETCP_ALIGN_UP   = 2'b01,
    ETCP_ALIGN_DOWN = 2'b10,
    ETCP_ALIGN_BOTH = 2'b11
  } etcp_align_t;
endpackage

//--- src/etcp_counter.sv
`timescale 1ns/1ps
`default_nettype none
module etcp_counter
  import etcp_pkg::*;
#(
  parameter int WIDTH = 10
) (
  // Clock and reset
  input  wire logic             hclk,
  input  wire logic             hresetn,
  // Control
  input  wire logic             run,
  input  wire logic             restart,
  input  wire logic             centre,
  // State
  output logic     [WIDTH-1:0]  count,
  output logic                  down
);
  localparam logic [WIDTH-1:0] TOP = '1;

  // Counter: up-wrap for edge, up/down for centre alignment
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      count <= '0;
      down  <= 1'b0;
    end else if (restart) begin
      count <= '0;
      down  <= 1'b0;
    end else if (run) begin
      if (!centre) begin
        count <= count + 1'b1;
        down  <= 1'b0;
      end else if (!down) begin
        if (count == TOP - 1'b1) begin
          down <= 1'b1;
        end
        count <= count + 1'b1;
      end else begin
        if (count == {{(WIDTH-1){1'b0}}, 1'b1}) begin
          down <= 1'b0;
        end
        count <= count - 1'b1;
      end
    end
  end
endmodule // etcp_counter
`default_nettype wire

//--- src/etcp_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "etcp_defs.svh"
module etcp_top
  import etcp_pkg::*;
#(
  parameter int WIDTH = 10
) (
  // Clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [11:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic        hready,
  input  wire logic [31:0] hwdata,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // Channel B output pin
  output logic             chan_b_output_pin,
  output logic             chan_b_output_pin_oen
);
  // ------------------------------------------------------------
  // Control register
  // ------------------------------------------------------------
  logic             module_run_bit;
  etcp_align_t      pwm_alignment_select;
  logic             chan_b_invert;
  logic             chan_b_initial_level;
  logic [1:0]       chan_b_action;
  etcp_mode_t       chan_b_mode;
  etcp_mode_t       chan_a_mode;
  logic [WIDTH-1:0] compare_value_a;
  logic [WIDTH-1:0] compare_value_b;
  logic [WIDTH-1:0] count;
  logic             down;
  logic             run_q;
  logic             run_rise;
  logic             pin_state;
  logic             pin_out;

  // ------------------------------------------------------------
  // Bus address phase capture
  // ------------------------------------------------------------
  logic        wr_pend;
  logic        rd_pend;
  logic [11:0] addr_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend <= 1'b0;
      rd_pend <= 1'b0;
      addr_q  <= 12'h000;
    end else if (hready) begin
      wr_pend <= hsel && htrans[1] && hwrite;
      rd_pend <= hsel && htrans[1] && !hwrite;
      addr_q  <= haddr;
    end
  end

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  function automatic logic hit(input logic [11:0] a, input logic [11:0] ofs);
    hit = (a[11:2] == ofs[11:2]);
  endfunction

  // ------------------------------------------------------------
  // Register writes
  // ------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      module_run_bit       <= 1'b0;
      pwm_alignment_select <= ETCP_ALIGN_EDGE;
      chan_b_invert        <= 1'b0;
      chan_b_initial_level <= 1'b0;
      chan_b_action        <= 2'b00;
      chan_b_mode          <= ETCP_MODE_COMPARE;
      chan_a_mode          <= ETCP_MODE_COMPARE;
    end else if (wr_pend && hit(addr_q, `ETCP_OFS_CTRL)) begin
      module_run_bit       <= hwdata[`ETCP_CTRL_RUN];
      pwm_alignment_select <= etcp_align_t'(hwdata[`ETCP_CTRL_ALIGN +: 2]);
      chan_b_invert        <= hwdata[`ETCP_CTRL_INVERT];
      chan_b_initial_level <= hwdata[`ETCP_CTRL_INIT];
      chan_b_action        <= hwdata[`ETCP_CTRL_BACT +: 2];
      chan_b_mode          <= etcp_mode_t'(hwdata[`ETCP_CTRL_BMODE +: 2]);
      chan_a_mode          <= etcp_mode_t'(hwdata[`ETCP_CTRL_AMODE +: 2]);
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      compare_value_a <= `ETCP_CMP_RST;
    end else if (wr_pend && hit(addr_q, `ETCP_OFS_CMPA_LO)) begin
      compare_value_a[7:0] <= hwdata[7:0];
    end else if (wr_pend && hit(addr_q, `ETCP_OFS_CMPA_HI)) begin
      compare_value_a[WIDTH-1:8] <= hwdata[WIDTH-9:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      compare_value_b <= `ETCP_CMP_RST;
    end else if (wr_pend && hit(addr_q, `ETCP_OFS_CMPB_LO)) begin
      compare_value_b[7:0] <= hwdata[7:0];
    end else if (wr_pend && hit(addr_q, `ETCP_OFS_CMPB_HI)) begin
      compare_value_b[WIDTH-1:8] <= hwdata[WIDTH-9:0];
    end
  end

  // ------------------------------------------------------------
  // Read data
  // ------------------------------------------------------------
  logic [31:0] rd_val;

  always_comb begin
    rd_val = 32'h0000_0000;
    if (hit(addr_q, `ETCP_OFS_CNT_LO)) begin
      rd_val[7:0] = count[7:0];
    end else if (hit(addr_q, `ETCP_OFS_CNT_HI)) begin
      rd_val[WIDTH-9:0] = count[WIDTH-1:8];
    end else if (hit(addr_q, `ETCP_OFS_CMPA_LO)) begin
      rd_val[7:0] = compare_value_a[7:0];
    end else if (hit(addr_q, `ETCP_OFS_CMPA_HI)) begin
      rd_val[WIDTH-9:0] = compare_value_a[WIDTH-1:8];
    end else if (hit(addr_q, `ETCP_OFS_CMPB_LO)) begin
      rd_val[7:0] = compare_value_b[7:0];
    end else if (hit(addr_q, `ETCP_OFS_CMPB_HI)) begin
      rd_val[WIDTH-9:0] = compare_value_b[WIDTH-1:8];
    end else if (hit(addr_q, `ETCP_OFS_CTRL)) begin
      rd_val[`ETCP_CTRL_RUN]        = module_run_bit;
      rd_val[`ETCP_CTRL_ALIGN +: 2] = pwm_alignment_select;
      rd_val[`ETCP_CTRL_INVERT]     = chan_b_invert;
      rd_val[`ETCP_CTRL_INIT]       = chan_b_initial_level;
      rd_val[`ETCP_CTRL_BACT +: 2]  = chan_b_action;
      rd_val[`ETCP_CTRL_BMODE +: 2] = chan_b_mode;
      rd_val[`ETCP_CTRL_AMODE +: 2] = chan_a_mode;
    end else if (hit(addr_q, `ETCP_OFS_STAT)) begin
      rd_val[0] = pin_out;
      rd_val[1] = down;
    end
  end

  // Counter bytes are sampled in the data phase, so reads see the live value
  assign hrdata = rd_pend ? rd_val : 32'h0000_0000;

  // ------------------------------------------------------------
  // Counter
  // ------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      run_q <= 1'b0;
    end else begin
      run_q <= module_run_bit;
    end
  end

  assign run_rise = module_run_bit && !run_q;

  etcp_counter #(
    .WIDTH (WIDTH)
  ) u_counter (
    .hclk    (hclk),
    .hresetn (hresetn),
    .run     (module_run_bit),
    .restart (run_rise),
    .centre  (pwm_alignment_select != ETCP_ALIGN_EDGE),
    .count   (count),
    .down    (down)
  );

  // ------------------------------------------------------------
  // Channel B output
  // ------------------------------------------------------------
  logic match_b;
  logic pwm_on;
  logic pwm_level;
  logic single_done;

  // Centre alignment: a compare match only counts in the selected direction
  function automatic logic dir_ok(input etcp_align_t al, input logic dn);
    if (al == ETCP_ALIGN_UP) begin
      dir_ok = !dn;
    end else if (al == ETCP_ALIGN_DOWN) begin
      dir_ok = dn;
    end else begin
      dir_ok = 1'b1;
    end
  endfunction

  assign match_b = module_run_bit && (count == compare_value_b)
                   && dir_ok(pwm_alignment_select, down);

  // Duty comparison is count below compare value B for every alignment
  always_comb begin
    case (pwm_alignment_select)
      ETCP_ALIGN_EDGE: pwm_on = (count < compare_value_b);
      default:         pwm_on = (count < compare_value_b);
    endcase
  end

  // Compare match output level, reloaded on run rising edge
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_state <= 1'b0;
    end else if (run_rise) begin
      pin_state <= chan_b_initial_level;
    end else if (match_b && chan_b_mode == ETCP_MODE_COMPARE) begin
      case (etcp_act_t'(chan_b_action))
        ETCP_ACT_LOW:    pin_state <= 1'b0;
        ETCP_ACT_HIGH:   pin_state <= 1'b1;
        ETCP_ACT_TOGGLE: pin_state <= !pin_state;
        default:         pin_state <= pin_state;
      endcase
    end
  end

  // Single pulse: one active period after start
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      single_done <= 1'b0;
    end else if (run_rise) begin
      single_done <= 1'b0;
    end else if (match_b) begin
      single_done <= 1'b1;
    end
  end

  always_comb begin
    case (etcp_pwm_act_t'(chan_b_action))
      ETCP_PWMA_FORCE_OFF: pwm_level = 1'b0;
      ETCP_PWMA_FORCE_ON:  pwm_level = 1'b1;
      ETCP_PWMA_PWM:       pwm_level = module_run_bit && pwm_on;
      default:             pwm_level = module_run_bit && !single_done;
    endcase
  end

  // Mode decides meaning of initial level bit; timer mode leaves pin alone
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_out               <= 1'b0;
      chan_b_output_pin_oen <= 1'b1;
    end else begin
      case (chan_b_mode)
        ETCP_MODE_COMPARE: begin
          pin_out               <= pin_state ^ chan_b_invert;
          chan_b_output_pin_oen <= 1'b0;
        end
        ETCP_MODE_PWM: begin
          pin_out               <= (pwm_level ^ !chan_b_initial_level) ^ chan_b_invert;
          chan_b_output_pin_oen <= 1'b0;
        end
        default: begin
          pin_out               <= 1'b0;
          chan_b_output_pin_oen <= 1'b1;
        end
      endcase
    end
  end

  assign chan_b_output_pin = pin_out;
endmodule // etcp_top
`default_nettype wire

//--- testbench/etcp_monitor.sv
`timescale 1ns/1ps
`default_nettype none
`include "etcp_defs.svh"
module etcp_monitor
  import etcp_pkg::*;
(
  // Clock and reset
  input wire logic        hclk,
  input wire logic        hresetn,
  // Bus
  input wire logic        hsel,
  input wire logic [11:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic [31:0] hwdata,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  // Pin
  input wire logic        chan_b_output_pin,
  input wire logic        chan_b_output_pin_oen
);
  logic        dp;
  logic        dw;
  logic [11:0] da;
  logic [10:0] ctl;
  logic [7:0]  cal;
  // ---------
  // Data phase
  // ---------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp <= 1'b0;
      dw <= 1'b0;
      da <= 12'h000;
    end else begin
      dp <= hsel && htrans[1] && hready;
      dw <= hwrite;
      da <= haddr;
    end
  end
  // Shadows of written registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctl <= 11'h000;
      cal <= 8'h00;
    end else if (dp && dw) begin
      if (da == `ETCP_OFS_CTRL) ctl <= hwdata[10:0];
      if (da == `ETCP_OFS_CMPA_LO) cal <= hwdata[7:0];
    end
  end
  // ---------
  // Properties
  // ---------
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  // Pin register lags both a control write and reset release by one cycle
  sequence s_hold;
    ($stable(ctl) && $past(hresetn))[*2];
  endsequence
  sequence s_rd;
    dp && !dw;
  endsequence
  a_ready_high: assert property (hreadyout && !hresp)
    else $error("bus not ready or not okay");
  a_float_off: assert property (s_hold ##0 ctl[7] |-> chan_b_output_pin_oen)
    else $error("pin driven in timer or capture");
  a_drive_on: assert property (s_hold ##0 !ctl[7] |-> !chan_b_output_pin_oen)
    else $error("pin undriven in output mode");
  a_pwm_force: assert property (s_hold ##0 ctl[0] && ctl[8:7] == 2'b10 && !ctl[6]
    |-> chan_b_output_pin == ((ctl[5] ~^ ctl[4]) ^ ctl[3])) else $error("forced level wrong");
  a_run_init: assert property ($rose(ctl[0]) && ctl[8:5] == 4'h0
    |-> ##[1:2] chan_b_output_pin == (ctl[4] ^ ctl[3])) else $error("initial level wrong");
  a_hi_zero: assert property (s_rd ##0 da[2] && da < 12'h018 |-> hrdata[31:2] == 30'h0)
    else $error("high byte upper bits set");
  a_cmpa_back: assert property (s_rd ##0 da == `ETCP_OFS_CMPA_LO |-> hrdata == {24'h0, cal})
    else $error("compare low byte readback wrong");
  a_unmapped_zero: assert property (s_rd ##0 da > 12'h01F |-> hrdata == 32'h0)
    else $error("unmapped read not zero");
endmodule // etcp_monitor
bind etcp_top etcp_monitor u_mon (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hready,
  .hwdata, .hrdata, .hreadyout, .hresp, .chan_b_output_pin, .chan_b_output_pin_oen);
`default_nettype wire

//--- testbench/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "etcp_defs.svh"
module tb_top
  import etcp_pkg::*;
;
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        hsel = 1'b0;
  logic [11:0] haddr = 12'h000;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [2:0]  hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic        pin;
  logic        oen;
  logic [31:0] rd;
  logic [31:0] r0;
  int          miscompares = 0;
  int          checks_done = 0;
  always #2.5 hclk = ~hclk;
  etcp_top dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize,
    .hready(hreadyout), .hwdata, .hrdata, .hreadyout, .hresp,
    .chan_b_output_pin(pin), .chan_b_output_pin_oen(oen));
  // ---------
  // Helpers
  // ---------
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rd = hrdata;
  endtask
  function automatic logic [31:0] cv(logic [1:0] ma, mb, act, logic ini, inv,
                                     logic [1:0] al, logic run);
    return {21'h0, ma, mb, act, ini, inv, al, run};
  endfunction
  task automatic print_verdict();
    if (miscompares == 0 && checks_done > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // ---------
  // Scenarios
  // ---------
  task automatic t_regs();
    for (int i = 0; i < 6; i++) begin
      bus(1'b0, 12'(i * 4), 32'h0);
      chk("reset", 32'h0, rd);
      bus(1'b1, 12'(i * 4), 32'hFFFF_FFFF);
      bus(1'b0, 12'(i * 4), 32'h0);
      chk("field", i < 2 ? 32'h0 : (i[0] ? 32'h3 : 32'hFF), rd);
    end
    bus(1'b1, 12'h040, 32'hFFFF_FFFF);
    bus(1'b0, 12'h040, 32'h0);
    chk("unmapped", 32'h0, rd);
  endtask
  task automatic t_count();
    bus(1'b1, `ETCP_OFS_CTRL, cv(0, 0, 0, 0, 0, 0, 1));
    bus(1'b0, `ETCP_OFS_CNT_LO, 32'h0);
    r0 = rd;
    bus(1'b0, `ETCP_OFS_CNT_LO, 32'h0);
    chk("count", r0 + 32'h2, rd);
  endtask
  task automatic t_init();
    for (int k = 0; k < 4; k++) begin
      bus(1'b1, `ETCP_OFS_CTRL, cv(0, 0, 0, k[1], k[0], 0, 0));
      bus(1'b1, `ETCP_OFS_CTRL, cv(0, 0, 0, k[1], k[0], 0, 1));
      repeat (3) @(posedge hclk);
      chk("pin", {30'h0, 1'b0, k[1] ^ k[0]}, {30'h0, oen, pin});
    end
  endtask
  task automatic t_pwm();
    for (int k = 0; k < 8; k++) begin
      bus(1'b1, `ETCP_OFS_CTRL, cv(0, 2, {1'b0, k[2]}, k[1], k[0], 0, 1));
      repeat (3) @(posedge hclk);
      chk("pin", {30'h0, 1'b0, (k[2] ~^ k[1]) ^ k[0]}, {30'h0, oen, pin});
    end
  endtask
  task automatic t_modes();
    logic [4:0] m[4] = '{5'b11111, 5'b01011, 5'b10000, 5'b11000};
    for (int k = 0; k < 4; k++) begin
      bus(1'b1, `ETCP_OFS_CTRL, cv(m[k][4:3], m[k][2:1], 0, 1, 1, 0, 1));
      repeat (3) @(posedge hclk);
      chk("oen", {31'h0, m[k][0]}, {31'h0, oen});
    end
  endtask
  task automatic t_align();
    for (int a = 0; a < 4; a++) begin
      bus(1'b1, `ETCP_OFS_CTRL, cv(0, 0, 0, 0, 0, 0, 0));
      bus(1'b1, `ETCP_OFS_CTRL, cv(0, 0, 0, 0, 0, a[1:0], 1));
      repeat (1100) @(posedge hclk);
      bus(1'b0, `ETCP_OFS_STAT, 32'h0);
      chk("down", {31'h0, a != 0}, {31'h0, rd[1]});
    end
  endtask
  task automatic t_wave();
    bus(1'b1, `ETCP_OFS_CMPB_LO, 32'h0000_0005);
    bus(1'b1, `ETCP_OFS_CMPB_HI, 32'h0000_0000);
    for (int k = 1; k < 6; k++) begin
      bus(1'b1, `ETCP_OFS_CTRL, cv(k > 3 ? 2 : 0, k > 3 ? 2 : 0, k > 3 ? k - 2 : k,
                                   k == 1 || k > 3, 0, 0, 0));
      bus(1'b1, `ETCP_OFS_CTRL, cv(k > 3 ? 2 : 0, k > 3 ? 2 : 0, k > 3 ? k - 2 : k,
                                   k == 1 || k > 3, 0, 0, 1));
      repeat (3) @(posedge hclk);
      chk("before", {31'h0, k != 2 && k != 3}, {31'h0, pin});
      repeat (10) @(posedge hclk);
      chk("after", {31'h0, k == 2 || k == 3}, {31'h0, pin});
    end
  endtask
  initial begin
    repeat (20000) @(posedge hclk);
    miscompares++;
    print_verdict();
  end
  initial begin
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_regs();
    t_count();
    t_init();
    t_pwm();
    t_modes();
    t_align();
    t_wave();
    print_verdict();
  end
endmodule // tb_top
`default_nettype wire
